// *** inc/cell_delin_pkg.sv ***
`default_nettype none
package cell_delin_pkg;
    // Cell geometry
    localparam int CELL_BYTES = 53;
    localparam int HDR_BYTES = 5;
    localparam int PAYLOAD_BYTES = 48;
    localparam int OUT_HDR_BYTES = 4;
    localparam logic [5:0] POS_CHECK = 6'h04;
    localparam logic [5:0] POS_FIRST_PAYLOAD = 6'h05;
    localparam logic [5:0] POS_HDR_OUT_LAST = 6'h08;
    localparam logic [5:0] POS_LAST = 6'h34;
    localparam int OUT_DELAY = 4;
    localparam int HIST_BITS = 48;

    // Header check code: x^8 + x^2 + x + 1, with coset added
    localparam logic [7:0] HCC_POLY = 8'h07;
    localparam logic [7:0] HCC_COSET = 8'h55;

    // Idle cell header, first four octets
    localparam logic [31:0] IDLE_HDR = 32'h00000001;

    // Descrambler x^43 + 1
    localparam int DESCR_LEN = 43;

    // Delineation thresholds
    localparam int SYNC_LOSS_BAD = 7;
    localparam int PRESYNC_GOOD = 6;

    // APB register map (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RX_COUNT = 8'h08;
    localparam logic [7:0] REG_DISC_COUNT = 8'h0C;

    // Control fields
    localparam int CTRL_CORR_ALLOW = 0;
    localparam int CTRL_DESCR_ALLOW = 1;
    localparam int CTRL_FORCE_HUNT = 2;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // Status fields
    localparam int STAT_OCD = 0;
    localparam int STAT_STATE_LSB = 1;
    localparam int STAT_DETECT = 3;
    localparam logic [1:0] STATE_CODE_HUNT = 2'h0;
    localparam logic [1:0] STATE_CODE_PRESYNC = 2'h1;
    localparam logic [1:0] STATE_CODE_SYNC = 2'h2;

    typedef enum logic [1:0] {ST_HUNT, ST_PRESYNC, ST_SYNC} delin_state_t;

    // One octet slot of the output delay line
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } octet_slot_t;

    // APB request carrier
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [7:0] addr;
        logic [31:0] wdata;
    } apb_req_t;
endpackage
`default_nettype wire

// *** design/atm_cell_delineation.sv ***
// What this block does
// - Accept 53-byte cells: five header octets then 48 payload octets.
// - Check code over four header octets, ATM polynomial, compared with fifth.
// - Eight parallel checks, one per bit offset, pick the byte alignment.
// - Aligned cells are classified as assigned or idle.
// - Correction mask from the check remainder repairs a single-bit error.
// - Correction attempted only while correction-enable input is high.
// - Descramble payload only, never header, with x^43+1 self-synchronising.
// - Descramble-enable changes take effect only at a cell boundary.
// - Data are sampled, and state advances other than a forced hunt, only when clock enable is high.
// - Output valid is high exactly when the output bus holds an octet.
// - Output cells are 52 octets; the check octet is removed.
// - Start-of-cell pulses one clock with the first output octet.
// - Cell-received pulses one clock per completely received assigned cell.
// - Cell-discarded pulses one clock per cell dropped for header error.
// - Out-of-delineation stays high while delineation is not achieved.
// - Delineation machine has hunt, presync and sync states.
// - Sync holds correction and detection sub-states for header errors.
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module atm_cell_delineation
    import cell_delin_pkg::*;
#(
    parameter int LOSS_BAD = SYNC_LOSS_BAD,
    parameter int GAIN_GOOD = PRESYNC_GOOD
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic [7:0] data_in,
    input wire logic corr_enable,
    input wire logic descr_enable,
    output logic [7:0] data_out,
    output logic out_valid,
    output logic soc_out,
    output logic cell_received,
    output logic cell_discarded,
    output logic out_of_delin,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // Header check code over 32 bits, MSB first
    function automatic logic [7:0] hcc_crc(input logic [31:0] d);
        logic [7:0] r;
        logic fb;
        r = 8'h00;
        for (int i = 31; i >= 0; i--)
        begin
            fb = r[7] ^ d[i];
            r = {r[6:0], 1'b0};
            if (fb)
            begin
                r = r ^ HCC_POLY;
            end
        end
        return r;
    endfunction

    // Remainder of a 40-bit header; zero means a good header
    function automatic logic [7:0] hcc_syndrome(input logic [39:0] h);
        return hcc_crc(h[39:8]) ^ HCC_COSET ^ h[7:0];
    endfunction

    // Single-bit mask whose syndrome matches; zero when none does
    function automatic logic [39:0] corr_mask(input logic [7:0] syn);
        logic [39:0] m;
        logic [39:0] e;
        m = 40'h0000000000;
        for (int j = 0; j < 40; j++)
        begin
            e = 40'h0000000001 << j;
            if ((hcc_crc(e[39:8]) ^ e[7:0]) == syn)
            begin
                m = e;
            end
        end
        return m;
    endfunction

    // Self-synchronising descrambler, one octet MSB first
    function automatic logic [50:0] descr_step(input logic [42:0] s, input logic [7:0] d);
        logic [42:0] st;
        logic [7:0] o;
        st = s;
        o = 8'h00;
        for (int i = 7; i >= 0; i--)
        begin
            o[i] = d[i] ^ st[DESCR_LEN-1];
            st = {st[DESCR_LEN-2:0], d[i]};
        end
        return {st, o};
    endfunction

    logic [HIST_BITS-1:0] hist_ff;
    logic [5:0] pos_ff;
    logic [2:0] align_ff;
    delin_state_t state_ff;
    logic detect_ff;
    logic [3:0] good_cnt_ff;
    logic [3:0] bad_cnt_ff;
    logic pass_ff;
    logic descr_cell_ff;
    logic [42:0] descr_ff;
    logic [31:0] hdr_ff;
    octet_slot_t delay_ff [OUT_DELAY];
    logic [1:0] ctrl_ff;
    logic [15:0] rx_count_ff;
    logic [15:0] disc_count_ff;
    logic [7:0] syn [8];
    logic [7:0] zero_hit;
    logic [2:0] hit_offset;
    logic [39:0] hdr_win;
    logic [7:0] syn_sel;
    logic [39:0] mask;
    logic [39:0] hdr_fixed;
    logic [7:0] aligned_byte;
    logic [50:0] descr_res;
    logic at_check;
    logic good_hdr;
    logic fixable;
    logic accept;
    logic is_idle;
    octet_slot_t slot_in;
    octet_slot_t slot_out;
    logic [5:0] nxt_pos;
    logic force_hunt;
    logic wr_en;
    logic rd_en;

    // Eight candidate alignments checked every enabled cycle
    generate
        for (genvar k = 0; k < 8; k++)
        begin : g_offset
            assign syn[k] = hcc_syndrome(hist_ff[k +: 40]);
            assign zero_hit[k] = (syn[k] == 8'h00);
        end
    endgenerate

    // Lowest matching offset wins when several match at once
    always_comb
    begin
        hit_offset = 3'h0;
        for (int k = 7; k >= 0; k--)
        begin
            if (zero_hit[k])
            begin
                hit_offset = 3'(k);
            end
        end
    end

    // Header window, syndrome and correction at the chosen alignment
    assign hdr_win = hist_ff[align_ff +: 40];
    assign aligned_byte = hist_ff[align_ff +: 8];
    assign syn_sel = syn[align_ff];
    assign mask = corr_mask(syn_sel);
    assign hdr_fixed = hdr_win ^ mask;
    assign at_check = clock_enable && (state_ff != ST_HUNT) && (pos_ff == POS_CHECK);
    assign good_hdr = (syn_sel == 8'h00);
    assign fixable = (mask != 40'h0000000000) && corr_enable && ctrl_ff[CTRL_CORR_ALLOW]
        && !detect_ff;
    assign accept = good_hdr || fixable;
    assign is_idle = (hdr_fixed[39:8] == IDLE_HDR);
    assign descr_res = descr_step(descr_ff, aligned_byte);
    assign force_hunt = wr_en && (paddr == REG_CTRL) && pwdata[CTRL_FORCE_HUNT];
    assign nxt_pos = (pos_ff == POS_LAST) ? 6'h00 : pos_ff + 6'h01;

    // Raw input history; held when the enable is low
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hist_ff <= '0;
        end
        else if (clock_enable)
        begin
            hist_ff <= {hist_ff[HIST_BITS-9:0], data_in};
        end
    end

    // Delineation state machine and cell position
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= ST_HUNT;
            pos_ff <= 6'h00;
            align_ff <= 3'h0;
            good_cnt_ff <= 4'h0;
            bad_cnt_ff <= 4'h0;
            detect_ff <= 1'b0;
        end
        else if (force_hunt)
        begin
            state_ff <= ST_HUNT;
            detect_ff <= 1'b0;
        end
        else if (clock_enable)
        begin
            case (state_ff)
                ST_HUNT:
                begin
                    // Octet-by-octet search over all bit offsets
                    if (zero_hit != 8'h00)
                    begin
                        state_ff <= ST_PRESYNC;
                        align_ff <= hit_offset;
                        pos_ff <= POS_FIRST_PAYLOAD;
                        good_cnt_ff <= 4'h0;
                    end
                end
                ST_PRESYNC:
                begin
                    pos_ff <= nxt_pos;
                    if (at_check && !good_hdr)
                    begin
                        state_ff <= ST_HUNT;
                    end
                    else if (at_check && (good_cnt_ff == 4'(GAIN_GOOD - 1)))
                    begin
                        state_ff <= ST_SYNC;
                        bad_cnt_ff <= 4'h0;
                        detect_ff <= 1'b0;
                    end
                    else if (at_check)
                    begin
                        good_cnt_ff <= good_cnt_ff + 4'h1;
                    end
                end
                ST_SYNC:
                begin
                    pos_ff <= nxt_pos;
                    if (at_check)
                    begin
                        // Any error leaves correction mode; a clean header returns to it
                        detect_ff <= !good_hdr;
                        if (accept)
                        begin
                            bad_cnt_ff <= 4'h0;
                        end
                        else if (bad_cnt_ff == 4'(LOSS_BAD - 1))
                        begin
                            state_ff <= ST_HUNT;
                            detect_ff <= 1'b0;
                        end
                        else
                        begin
                            bad_cnt_ff <= bad_cnt_ff + 4'h1;
                        end
                    end
                end
                default:
                begin
                    state_ff <= ST_HUNT;
                end
            endcase
        end
    end

    // Per-cell decision and the header kept for output
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pass_ff <= 1'b0;
            hdr_ff <= 32'h00000000;
            descr_cell_ff <= 1'b0;
        end
        else if (force_hunt)
        begin
            pass_ff <= 1'b0;
        end
        else if (clock_enable && state_ff == ST_HUNT)
        begin
            pass_ff <= 1'b0;
        end
        else if (at_check)
        begin
            pass_ff <= (state_ff == ST_SYNC) && accept && !is_idle;
            hdr_ff <= hdr_fixed[39:8];
            descr_cell_ff <= descr_enable && ctrl_ff[CTRL_DESCR_ALLOW];
        end
    end

    // Descrambler state runs over payload only so it stays synchronised
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            descr_ff <= '0;
        end
        else if (clock_enable && state_ff != ST_HUNT && pos_ff >= POS_FIRST_PAYLOAD)
        begin
            descr_ff <= descr_res[50:8];
        end
    end

    // Payload enters a four-slot delay so the header can go out first
    always_comb
    begin
        slot_in.valid = pass_ff && (state_ff != ST_HUNT) && (pos_ff >= POS_FIRST_PAYLOAD);
        slot_in.data = descr_cell_ff ? descr_res[7:0] : aligned_byte;
        if (pos_ff >= POS_FIRST_PAYLOAD && pos_ff <= POS_HDR_OUT_LAST && state_ff != ST_HUNT)
        begin
            // Check octet slot is skipped: 52 outputs per 53 inputs
            slot_out.valid = pass_ff;
            slot_out.data = hdr_ff[8*(3 - (pos_ff - POS_FIRST_PAYLOAD)) +: 8];
        end
        else
        begin
            slot_out = delay_ff[OUT_DELAY-1];
        end
    end

    // Delay line shifts only on enabled cycles
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int i = 0; i < OUT_DELAY; i++)
            begin
                delay_ff[i] <= '0;
            end
        end
        else if (clock_enable)
        begin
            delay_ff[0] <= slot_in;
            for (int i = 1; i < OUT_DELAY; i++)
            begin
                delay_ff[i] <= delay_ff[i-1];
            end
        end
    end

    // Registered cell outputs; nothing is valid in the cycle after a disabled cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            data_out <= 8'h00;
            out_valid <= 1'b0;
            soc_out <= 1'b0;
            cell_received <= 1'b0;
            cell_discarded <= 1'b0;
            out_of_delin <= 1'b1;
        end
        else
        begin
            data_out <= slot_out.data;
            out_valid <= clock_enable && slot_out.valid;
            soc_out <= clock_enable && slot_out.valid && (pos_ff == POS_FIRST_PAYLOAD);
            cell_received <= clock_enable && pass_ff && (pos_ff == POS_LAST)
                && (state_ff == ST_SYNC);
            cell_discarded <= at_check && (state_ff == ST_SYNC) && !accept;
            out_of_delin <= (state_ff != ST_SYNC);
        end
    end

    // Statistics counters wrap; software takes differences
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_count_ff <= 16'h0000;
            disc_count_ff <= 16'h0000;
        end
        else
        begin
            if (clock_enable && pass_ff && pos_ff == POS_LAST && state_ff == ST_SYNC)
            begin
                rx_count_ff <= rx_count_ff + 16'h0001;
            end
            if (at_check && state_ff == ST_SYNC && !accept)
            begin
                disc_count_ff <= disc_count_ff + 16'h0001;
            end
        end
    end

    // APB slave: no wait states, ready raised in the first access-phase cycle
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && !penable;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr != REG_CTRL) && (paddr != REG_STATUS)
                && (paddr != REG_RX_COUNT) && (paddr != REG_DISC_COUNT);
            if (rd_en && !pwrite)
            begin
                case (paddr)
                    REG_CTRL: prdata <= {30'h00000000, ctrl_ff};
                    REG_STATUS:
                    begin
                        prdata <= 32'h00000000;
                        prdata[STAT_OCD] <= (state_ff != ST_SYNC);
                        prdata[STAT_STATE_LSB +: 2] <= (state_ff == ST_SYNC) ? STATE_CODE_SYNC :
                            (state_ff == ST_PRESYNC) ? STATE_CODE_PRESYNC : STATE_CODE_HUNT;
                        prdata[STAT_DETECT] <= detect_ff;
                    end
                    REG_RX_COUNT: prdata <= {16'h0000, rx_count_ff};
                    REG_DISC_COUNT: prdata <= {16'h0000, disc_count_ff};
                    default: prdata <= 32'h00000000;
                endcase
            end
            else if (rd_en)
            begin
                prdata <= 32'h00000000;
            end
        end
    end

    // Control register gates the enable pins
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_ff <= CTRL_RESET;
        end
        else if (wr_en && paddr == REG_CTRL)
        begin
            ctrl_ff <= pwdata[1:0];
        end
    end

endmodule
`default_nettype wire

// *** verification/cell_delin_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module cell_delin_props
    import cell_delin_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clock_enable,
    input wire logic psel,
    input wire logic penable,
    input wire logic out_valid,
    input wire logic soc_out,
    input wire logic cell_received,
    input wire logic cell_discarded,
    input wire logic out_of_delin,
    input wire logic pready
);
    logic [6:0] octets_ff;

    // Octets shown since the last start of cell; tracks the 52-octet framing
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            octets_ff <= 7'h00;
        else if (soc_out)
            octets_ff <= 7'h01;
        else if (out_valid)
            octets_ff <= octets_ff + 7'h01;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    hold_when_idle_a: assert property (!clock_enable |=> !out_valid)
        else $error("output octet after a disabled cycle");
    soc_has_octet_a: assert property (soc_out |-> out_valid)
        else $error("start of cell without an octet");
    soc_single_a: assert property (soc_out |=> !soc_out)
        else $error("start of cell wider than one clock");
    cell_length_a: assert property (soc_out && octets_ff != 7'h00 |-> octets_ff == 7'h34)
        else $error("previous cell not 52 octets");
    octet_in_cell_a: assert property (out_valid && !soc_out |-> octets_ff inside {[7'h01:7'h33]})
        else $error("octet outside a cell");
    rx_pulse_a: assert property (cell_received |=> !cell_received)
        else $error("received pulse wider than one clock");
    drop_pulse_a: assert property (cell_discarded |=> !cell_discarded)
        else $error("discard pulse wider than one clock");
    drop_in_sync_a: assert property (cell_discarded |-> !$past(out_of_delin))
        else $error("discard outside delineation");
    rx_in_sync_a: assert property (cell_received |-> !out_of_delin)
        else $error("received pulse while out of delineation");
    quiet_hunt_a: assert property (out_of_delin |-> !out_valid)
        else $error("octet shown while out of delineation");
    apb_answer_a: assert property (psel && !penable |=> pready [*1] ##1 !pready)
        else $error("register access not answered in one cycle");
endmodule

bind atm_cell_delineation cell_delin_props props_u (
    .sys_clk(sys_clk), .reset_n(reset_n), .clock_enable(clock_enable),
    .psel(psel), .penable(penable), .out_valid(out_valid), .soc_out(soc_out),
    .cell_received(cell_received), .cell_discarded(cell_discarded),
    .out_of_delin(out_of_delin), .pready(pready)
);
`default_nettype wire

// *** verification/cell_source.sv ***
`timescale 1ns/1ns
`default_nettype none
module cell_source
    import cell_delin_pkg::*;
(
    input wire logic sys_clk,
    input wire logic clock_enable,
    output logic [7:0] data_in
);
    logic bits_q[$];

    // Check octet appended by the framer, coset included
    function automatic logic [7:0] check_octet(input logic [31:0] hdr);
        logic [7:0] crc;
        crc = 8'h00;
        for (int i = 31; i >= 0; i--)
            crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ hdr[i]) ? HCC_POLY : 8'h00);
        return crc ^ HCC_COSET;
    endfunction

    // Bits leave MSB first, so cells need not sit on octet edges
    task automatic put_bits(input logic [39:0] val, input int n);
        for (int i = n - 1; i >= 0; i--)
            bits_q.push_back(val[i]);
    endtask

    // Header and check octet, with any flips the bench wants injected
    task automatic put_header(input logic [31:0] hdr, input logic [39:0] flip);
        put_bits({hdr, check_octet(hdr)} ^ flip, 40);
    endtask

    // One octet per enabled cycle; a dry queue sends a toggling pattern
    initial data_in = 8'h5A;
    always @(posedge sys_clk)
    begin
        if (clock_enable)
        begin
            if (bits_q.size() >= 8)
            begin
                for (int i = 7; i >= 0; i--)
                    data_in[i] <= bits_q.pop_front();
            end
            else
                data_in <= ~data_in;
        end
    end
endmodule
`default_nettype wire

// *** verification/atm_cell_delineation_bench.sv ***
`timescale 1ns/1ns
`default_nettype none
module atm_cell_delineation_bench
    import cell_delin_pkg::*;
;
    logic sys_clk, reset_n, clock_enable, corr_enable, descr_enable, err, prev_ff, detect;
    logic out_valid, soc_out, cell_received, cell_discarded, out_of_delin;
    logic psel, penable, pwrite, pready, pslverr;
    logic [7:0] data_in, data_out, paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] note;
    logic [9:0] exp_q[$];
    integer seed = 32'h1e517cb6;
    int n_fail = 0, checks = 0, exp_rx = 0, exp_drop = 0, got_rx = 0, got_drop = 0;
    int first_out = -1, cell_no = 0;

    atm_cell_delineation dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .clock_enable(clock_enable), .data_in(data_in), .corr_enable(corr_enable),
        .descr_enable(descr_enable), .data_out(data_out), .out_valid(out_valid),
        .soc_out(soc_out), .cell_received(cell_received), .cell_discarded(cell_discarded),
        .out_of_delin(out_of_delin), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    cell_source src_u (.sys_clk(sys_clk), .clock_enable(clock_enable), .data_in(data_in));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Register access: held from setup until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        @(posedge sys_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, addr, wd};
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask

    // Queue a cell upstream; kind 0 clean, 1 one flip, 2 two flips, 3 idle
    task automatic send_cell(input int kind, input logic ff, input logic corr, input logic descr);
        logic [31:0] hdr;
        logic [39:0] flip;
        logic [7:0] pay;
        logic live, ok;
        hdr = $random(seed);
        hdr[28] = 1'b1;
        flip = 40'h0;
        if (kind == 3)
            hdr = IDLE_HDR;
        if (kind == 1 || kind == 2)
            flip[8 + ($random(seed) & 15)] = 1'b1;
        if (kind == 2)
            flip[24 + ($random(seed) & 15)] = 1'b1;
        while (src_u.bits_q.size() >= 24)
            @(negedge sys_clk);
        // Enables change after the previous check, before this one
        @(posedge sys_clk);
        corr_enable <= corr;
        descr_enable <= descr;
        @(negedge sys_clk);
        live = (out_of_delin === 1'b0);
        ok = (kind == 0) || (kind == 3) || (kind == 1 && corr && !detect);
        detect = (kind == 1 || kind == 2);
        if (live && first_out < 0)
            first_out = cell_no;
        if (live && !ok)
            exp_drop++;
        if (live && ok && kind != 3)
            exp_rx++;
        src_u.put_header(hdr, flip);
        for (int i = 3; i >= 0 && live && ok && kind != 3; i--)
            exp_q.push_back({1'b1, i == 3, hdr[8 * i +: 8]});
        for (int i = 0; i < 48; i++)
        begin
            pay = ff ? 8'hFF : 8'($random(seed));
            src_u.put_bits({32'h0, pay}, 8);
            if (live && ok && kind != 3)
                exp_q.push_back({2'h2, (ff && descr && prev_ff) ? 8'h00 : pay});
        end
        prev_ff = ff;
        cell_no++;
    endtask

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Enable drops about one cycle in eight
    always @(posedge sys_clk)
        clock_enable <= ($random(seed) & 7) != 0;

    // Each shown octet is compared with the oldest note
    always @(posedge sys_clk)
    begin
        if (reset_n === 1'b1)
        begin
            got_rx += (cell_received === 1'b1);
            got_drop += (cell_discarded === 1'b1);
            if (out_valid === 1'b1 && exp_q.size() == 0)
                check("unexpected octet", 32'h1, 32'h0);
            else if (out_valid === 1'b1)
            begin
                note = exp_q.pop_front();
                if (note[9])
                    check("octet", 32'(data_out), 32'(note[7:0]));
                check("start of cell", 32'(soc_out), 32'(note[8]));
            end
        end
    end

    // Cut a hang short well beyond the few thousand cycles the tests need
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        check("watchdog", 32'h1, 32'h0);
        report_and_stop();
    end

    initial
    begin
        reset_n = 1'b0;
        {corr_enable, descr_enable, clock_enable, prev_ff, detect} = 5'h10;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        check("control reset", rd, 32'h3);
        apb(1'b1, 8'h10, 32'hFFFFFFFF);
        check("unmapped write error", 32'(err), 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped read data", rd, 32'h0);
        src_u.put_bits(40'h5, 3);
        repeat (16) send_cell(0, 1'b0, 1'b1, 1'b0);
        check("acquired after six good", 32'(first_out >= 7), 32'h1);
        apb(1'b0, REG_STATUS, 32'h0);
        check("sync status", 32'(rd[2:0]), 32'({STATE_CODE_SYNC, 1'b0}));
        $display("acquisition done");
        send_cell(3, 1'b0, 1'b1, 1'b0);
        send_cell(1, 1'b0, 1'b1, 1'b0);
        send_cell(1, 1'b0, 1'b1, 1'b0);
        send_cell(0, 1'b0, 1'b1, 1'b0);
        send_cell(1, 1'b0, 1'b0, 1'b0);
        send_cell(0, 1'b1, 1'b1, 1'b0);
        send_cell(0, 1'b1, 1'b1, 1'b1);
        send_cell(0, 1'b1, 1'b1, 1'b0);
        send_cell(0, 1'b0, 1'b1, 1'b0);
        $display("correction and descrambling done");
        repeat (2) send_cell(3, 1'b0, 1'b1, 1'b0);
        apb(1'b1, REG_CTRL, 32'h7);
        repeat (2) @(posedge sys_clk);
        check("forced hunt", 32'(out_of_delin), 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        check("force bit clears", rd, 32'h3);
        repeat (14) send_cell(0, 1'b0, 1'b1, 1'b0);
        repeat (6) send_cell(2, 1'b0, 1'b1, 1'b0);
        send_cell(0, 1'b0, 1'b1, 1'b0);
        check("sync kept after six bad", 32'(out_of_delin), 32'h0);
        repeat (7) send_cell(2, 1'b0, 1'b1, 1'b0);
        send_cell(3, 1'b0, 1'b1, 1'b0);
        check("sync lost after seven bad", 32'(out_of_delin), 32'h1);
        $display("loss of delineation done");
        for (int w = 0; w < 500 && exp_q.size() != 0; w++)
            @(posedge sys_clk);
        check("all octets shown", exp_q.size(), 32'h0);
        check("received pulses", got_rx, exp_rx);
        check("discard pulses", got_drop, exp_drop);
        apb(1'b0, REG_RX_COUNT, 32'h0);
        check("received count", rd, exp_rx & 32'hFFFF);
        apb(1'b0, REG_DISC_COUNT, 32'h0);
        check("discard count", rd, exp_drop & 32'hFFFF);
        $display("counters done");
        report_and_stop();
    end
endmodule
`default_nettype wire
